// File: core/bad_pkg.sv
/*
 Package for the board address decoder: widths, address map and field positions.
 Assumes nothing of its surroundings.
*/
package bad_pkg;
   localparam int BAD_ADDR_W = 16;
   localparam int BAD_DATA_W = 8;
   localparam logic [15:0] BAD_PRAM_LO = 16'h0000;
   localparam logic [15:0] BAD_PRAM_HI = 16'h01ff;
   localparam logic [15:0] BAD_ROM_LO = 16'h7c00;
   localparam logic [15:0] BAD_ROM_HI = 16'h7fff;
   localparam logic [15:0] BAD_VRAM_LO = 16'hffc0;
   localparam logic [15:0] BAD_VRAM_HI = 16'hffff;
   localparam logic [15:0] BAD_PPA_LO = 16'h4000;
   localparam logic [15:0] BAD_PPA_HI = 16'h4003;
   localparam logic [15:0] BAD_PPA_REGION_LO = 16'h4000;
   localparam logic [15:0] BAD_PPA_REGION_HI = 16'h5c03;
   localparam logic [15:0] BAD_MIO_LO = 16'h6200;
   localparam logic [15:0] BAD_MIO_HI = 16'h6e07;
   localparam logic [15:0] BAD_MIO_IGNORE_MASK = 16'hf3ff;
   localparam logic [15:0] BAD_MIO_BASE = 16'h6200;
   localparam logic [15:0] BAD_MIO_MATCH_MASK = 16'hf3f8;
   localparam int BAD_A15_POS = 15;
   localparam int BAD_GRP_LSB = 8;
   localparam int BAD_GRP_W = 4;
   localparam int BAD_BLK_LSB = 12;
   localparam int BAD_BLK_W = 4;
   localparam int BAD_NGRP = 16;
   localparam int BAD_LOW_W = 8;
   localparam logic [3:0] BAD_BLK_RST = 4'h0;
endpackage

// File: core/bad_bus_if.sv
/*
 Processor bus between the decoder board and the bus master.
 Assumes the master drives address, phase clocks and write, and samples ready, on clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface bad_bus_if;
   import bad_pkg::*;
   logic [BAD_ADDR_W-1:0] addr;
   logic [BAD_DATA_W-1:0] data_m2d;
   logic [BAD_DATA_W-1:0] data_d2m;
   logic data_d2m_oe;
   logic we;
   logic phase1_clock;
   logic phase2_clock;
   logic cpu_resetn;
   logic rdy;
   logic irq_n;
   logic nmi_n;
   logic forced_addr_bit15;
   modport dev (input addr, data_m2d, we, phase1_clock, phase2_clock, cpu_resetn, nmi_n,
      output data_d2m, data_d2m_oe, rdy, irq_n, forced_addr_bit15);
   modport mst (output addr, data_m2d, we, phase1_clock, phase2_clock, cpu_resetn, nmi_n,
      input data_d2m, data_d2m_oe, rdy, irq_n, forced_addr_bit15);
endinterface
`default_nettype wire

// File: core/bad_decode.sv
/*
 Board address decoder: on-board selects, RAM card page and card decode, strobes,
 interrupt routing and the forced address bit during reset.
 Assumes the bus master behind bad_bus_if.mst; selects are registered one cycle late.
*/
// Behaviour
// - 16-bit address, 8-bit data bus.
// - Program RAM at 0000 to 01ff.
// - Monitor ROM at 7c00 to 7fff.
// - Vector RAM at ffc0 to ffff.
// - Address bit 15 forced low in reset.
// - Parallel port adapter at 4000 to 4003.
// - 4000 to 5c03 reserved for adapters.
// - Multifunction chip decode ignores A10, A11.
// - Maskable and non-maskable interrupt inputs.
// - Jumpers route adapter interrupts to irq.
// - Slow device holds ready low.
// - Tape reader uses multifunction ports.
// - RAM card: sixteen 256-byte groups.
// - A8..A11 decoded one of sixteen.
// - Card enabled when A12..A15 match jumpers.
// - A0..A7 pass straight to chips.
// - Write strobe low during write phase two.
// - Read/write level high during write.
`timescale 1ns/1ps
`default_nettype none
module bad_decode
   import bad_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   bad_bus_if.dev bus,
   input wire logic [1:0] ppa_irq_n_i,
   input wire logic [1:0] irq_jumper_i,
   input wire logic [BAD_BLK_W-1:0] card_blk_i,
   input wire logic dev_ready_i,
   input wire logic [BAD_DATA_W-1:0] rd_data_i,
   output logic pram_sel_o,
   output logic rom_sel_o,
   output logic vram_sel_o,
   output logic ppa_sel_o,
   output logic mio_sel_o,
   output logic card_en_o,
   output logic [BAD_NGRP-1:0] grp_sel_o,
   output logic [BAD_LOW_W-1:0] chip_addr_o,
   output logic write_n_o,
   output logic rw_o,
   output logic [BAD_DATA_W-1:0] wr_data_o
);
   // Board pins: adapter interrupts, interrupt jumpers, card block jumpers, device ready.
   localparam int PIN_W = 2 + 2 + BAD_BLK_W + 1;
   localparam logic [PIN_W-1:0] PIN_RST = {2'b11, 2'b00, BAD_BLK_RST, 1'b0};
   logic [BAD_ADDR_W-1:0] eff_addr;
   logic pram_hit;
   logic rom_hit;
   logic vram_hit;
   logic ppa_hit;
   logic mio_hit;
   logic ppa_region;
   logic card_hit;
   logic any_hit;
   logic [BAD_NGRP-1:0] grp_dec;
   logic irq_nxt;
   logic pram_sel_r;
   logic rom_sel_r;
   logic vram_sel_r;
   logic ppa_sel_r;
   logic mio_sel_r;
   logic card_en_r;
   logic [BAD_NGRP-1:0] grp_sel_r;
   logic [BAD_LOW_W-1:0] chip_addr_r;
   logic write_n_r;
   logic rw_r;
   logic irq_n_r;
   logic rdy_r;
   logic oe_r;
   logic a15_r;
   logic [BAD_DATA_W-1:0] wr_data_r;
   logic [BAD_DATA_W-1:0] rd_data_r;
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic [PIN_W-1:0] pin_s3_r;
   logic [PIN_W-1:0] pin_flt_r;
   logic [PIN_W-1:0] pin_flt_nxt;
   logic [1:0] ppa_irq_n_s;
   logic [1:0] irq_jumper_s;
   logic [BAD_BLK_W-1:0] blk_s;
   logic dev_ready_s;

   // The effective top bit is cleared while the processor is held in reset.
   assign eff_addr = {bus.addr[BAD_A15_POS] & bus.cpu_resetn, bus.addr[BAD_A15_POS-1:0]};
   assign pram_hit = (eff_addr >= BAD_PRAM_LO) && (eff_addr <= BAD_PRAM_HI);
   assign rom_hit = (eff_addr >= BAD_ROM_LO) && (eff_addr <= BAD_ROM_HI);
   assign vram_hit = (eff_addr >= BAD_VRAM_LO) && (eff_addr <= BAD_VRAM_HI);
   assign ppa_region = (eff_addr >= BAD_PPA_REGION_LO) && (eff_addr <= BAD_PPA_REGION_HI);
   assign ppa_hit = ppa_region && (eff_addr >= BAD_PPA_LO) && (eff_addr <= BAD_PPA_HI);
   // Aliases produced by ignoring A10 and A11 are accepted.
   assign mio_hit = ((eff_addr & BAD_MIO_MATCH_MASK) == (BAD_MIO_BASE & BAD_MIO_MATCH_MASK))
      && ((eff_addr & BAD_MIO_IGNORE_MASK) >= (BAD_MIO_LO & BAD_MIO_IGNORE_MASK))
      && (eff_addr <= BAD_MIO_HI);
   assign card_hit = (eff_addr[BAD_BLK_LSB +: BAD_BLK_W] == blk_s);
   assign any_hit = pram_hit | rom_hit | vram_hit | ppa_hit | mio_hit | card_hit;
   assign irq_nxt = ~((~ppa_irq_n_s[0] & irq_jumper_s[0])
      | (~ppa_irq_n_s[1] & irq_jumper_s[1]));

   genvar g;
   generate
      for (g = 0; g < BAD_NGRP; g++)
      begin : gen_grp
         assign grp_dec[g] = card_hit && (eff_addr[BAD_GRP_LSB +: BAD_GRP_W] == BAD_GRP_W'(g));
      end
   endgenerate

   // Board pins pass three flops; a bit moves on only once the last two agree.
   assign pin_raw = {ppa_irq_n_i, irq_jumper_i, card_blk_i, dev_ready_i};
   generate
      for (g = 0; g < PIN_W; g++)
      begin : gen_pin
         assign pin_flt_nxt[g] = (pin_s2_r[g] == pin_s3_r[g]) ? pin_s3_r[g] : pin_flt_r[g];
      end
   endgenerate
   assign {ppa_irq_n_s, irq_jumper_s, blk_s, dev_ready_s} = pin_flt_r;

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pin_s1_r <= PIN_RST;
         pin_s2_r <= PIN_RST;
         pin_s3_r <= PIN_RST;
         pin_flt_r <= PIN_RST;
      end
      else
      begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_flt_r <= pin_flt_nxt;
      end
   end

   // Selects follow the address with one clock of latency.
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pram_sel_r <= 1'b0;
         rom_sel_r <= 1'b0;
         vram_sel_r <= 1'b0;
         ppa_sel_r <= 1'b0;
         mio_sel_r <= 1'b0;
         card_en_r <= 1'b0;
         grp_sel_r <= '0;
         chip_addr_r <= '0;
         a15_r <= 1'b0;
      end
      else
      begin
         pram_sel_r <= pram_hit;
         rom_sel_r <= rom_hit;
         vram_sel_r <= vram_hit;
         ppa_sel_r <= ppa_hit;
         mio_sel_r <= mio_hit;
         card_en_r <= card_hit;
         grp_sel_r <= grp_dec;
         chip_addr_r <= eff_addr[BAD_LOW_W-1:0];
         a15_r <= eff_addr[BAD_A15_POS];
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         write_n_r <= 1'b1;
         rw_r <= 1'b0;
         irq_n_r <= 1'b1;
         rdy_r <= 1'b0;
         oe_r <= 1'b0;
         wr_data_r <= '0;
         rd_data_r <= '0;
      end
      else
      begin
         write_n_r <= ~(bus.we & bus.phase2_clock);
         rw_r <= bus.we;
         irq_n_r <= irq_nxt;
         rdy_r <= dev_ready_s;
         oe_r <= ~bus.we & any_hit;
         wr_data_r <= bus.data_m2d;
         rd_data_r <= rd_data_i;
      end
   end

   assign pram_sel_o = pram_sel_r;
   assign rom_sel_o = rom_sel_r;
   assign vram_sel_o = vram_sel_r;
   assign ppa_sel_o = ppa_sel_r;
   assign mio_sel_o = mio_sel_r;
   assign card_en_o = card_en_r;
   assign grp_sel_o = grp_sel_r;
   assign chip_addr_o = chip_addr_r;
   assign write_n_o = write_n_r;
   assign rw_o = rw_r;
   assign wr_data_o = wr_data_r;
   assign bus.data_d2m = rd_data_r;
   assign bus.data_d2m_oe = oe_r;
   assign bus.rdy = rdy_r;
   assign bus.irq_n = irq_n_r;
   assign bus.forced_addr_bit15 = a15_r;
endmodule
`default_nettype wire

// File: core/bad_master.sv
/*
 Bus master end: drives one access per request and waits on ready.
 Assumes bad_decode on the dev modport, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bad_master
   import bad_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   bad_bus_if.mst bus,
   input wire logic req_i,
   input wire logic req_we_i,
   input wire logic [BAD_ADDR_W-1:0] req_addr_i,
   input wire logic [BAD_DATA_W-1:0] req_wdata_i,
   input wire logic nmi_req_i,
   output logic busy_o,
   output logic done_o,
   output logic [BAD_DATA_W-1:0] rdata_o,
   output logic irq_pending_o
);
   typedef enum logic [1:0] {BAD_IDLE = 2'b00, BAD_PH1 = 2'b01, BAD_PH2 = 2'b10} bad_state_t;
   bad_state_t st_r, st_nxt;
   logic [BAD_ADDR_W-1:0] addr_r;
   logic [BAD_DATA_W-1:0] wd_r, rd_r;
   logic we_r, done_r, irq_r, start, finish;

   assign start = (st_r == BAD_IDLE) && req_i;
   // A slow device stretches phase two by holding ready low.
   assign finish = (st_r == BAD_PH2) && bus.rdy;
   always_comb
   begin
      case (st_r)
         BAD_IDLE: st_nxt = start ? BAD_PH1 : BAD_IDLE;
         BAD_PH1: st_nxt = BAD_PH2;
         BAD_PH2: st_nxt = finish ? BAD_IDLE : BAD_PH2;
         default: st_nxt = BAD_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_r <= BAD_IDLE;
         addr_r <= '0;
         wd_r <= '0;
         we_r <= 1'b0;
         rd_r <= '0;
         done_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         done_r <= finish;
         irq_r <= ~bus.irq_n;
         if (start)
         begin
            addr_r <= req_addr_i;
            wd_r <= req_wdata_i;
            we_r <= req_we_i;
         end
         if (finish && !we_r)
         begin
            rd_r <= bus.data_d2m;
         end
      end
   end

   assign bus.addr = addr_r;
   assign bus.data_m2d = wd_r;
   assign bus.we = we_r && (st_r != BAD_IDLE);
   assign bus.phase1_clock = (st_r == BAD_PH1);
   assign bus.phase2_clock = (st_r == BAD_PH2);
   assign bus.cpu_resetn = resetn_i;
   assign bus.nmi_n = ~nmi_req_i;
   assign busy_o = (st_r != BAD_IDLE);
   assign done_o = done_r;
   assign rdata_o = rd_r;
   assign irq_pending_o = irq_r;
endmodule
`default_nettype wire

// File: testbench/bad_chk.sv
/* Assertions on the decoder bus and select outputs.
 Assumes instantiation beside bad_bus_if with decoder outputs wired by name. */
`timescale 1ns/1ps
`default_nettype none
module bad_chk
   import bad_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [BAD_ADDR_W-1:0] addr,
   input wire logic we,
   input wire logic phase2_clock,
   input wire logic cpu_resetn,
   input wire logic forced_addr_bit15,
   input wire logic pram_sel_o,
   input wire logic rom_sel_o,
   input wire logic vram_sel_o,
   input wire logic ppa_sel_o,
   input wire logic mio_sel_o,
   input wire logic card_en_o,
   input wire logic [BAD_NGRP-1:0] grp_sel_o,
   input wire logic [BAD_LOW_W-1:0] chip_addr_o,
   input wire logic write_n_o,
   input wire logic rw_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   logic [15:0] ea;
   assign ea = {addr[15] & cpu_resetn, addr[14:0]};
   sequence s_wr_ph2;
      we && phase2_clock;
   endsequence
   chk_pram_range: assert property ($past(resetn_i) |->
      pram_sel_o == ($past(ea) <= 16'h01ff)) else $error("pram select");
   chk_rom_range: assert property ($past(resetn_i) |->
      rom_sel_o == ($past(ea) >= 16'h7c00 && $past(ea) <= 16'h7fff)) else $error("rom select");
   chk_vram_range: assert property ($past(resetn_i) |->
      vram_sel_o == ($past(ea) >= 16'hffc0)) else $error("vram select");
   chk_ppa_range: assert property ($past(resetn_i) |->
      ppa_sel_o == ($past(ea[15:2]) == 14'h1000)) else $error("ppa select");
   chk_mio_alias: assert property ($past(resetn_i) |->
      mio_sel_o == (($past(ea) & 16'hf3f8) == 16'h6200)) else $error("mio select");
   chk_sel_exclusive: assert property (
      $onehot0({pram_sel_o, rom_sel_o, vram_sel_o, ppa_sel_o, mio_sel_o})) else $error("overlap");
   chk_a15_forced: assert property ($past(resetn_i) |->
      forced_addr_bit15 == $past(addr[15] & cpu_resetn)) else $error("forced bit");
   chk_wstrobe_low: assert property (s_wr_ph2 |=> !write_n_o) else $error("strobe low");
   chk_rw_level: assert property ($past(resetn_i) |->
      rw_o == $past(we)) else $error("rw level");
   chk_group_onehot: assert property (
      card_en_o ? $onehot(grp_sel_o) : grp_sel_o == 16'h0) else $error("group select");
   chk_low_addr_pass: assert property ($past(resetn_i) |->
      chip_addr_o == $past(addr[7:0])) else $error("chip address");
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/* Self-checking bench: decoder and master joined by bad_bus_if.
 Assumes the core files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import bad_pkg::*;
;
   logic clk_sys_i = 0, resetn_i = 0, req_i = 0, req_we_i = 0, nmi_req_i = 0, dev_ready_i = 1;
   logic [15:0] req_addr_i = 16'h0;
   logic [7:0] req_wdata_i = 8'h0, rd_data_i = 8'h5a, chip_addr_o, wr_data_o, rdata_o;
   logic [1:0] ppa_irq_n_i = 2'h3, irq_jumper_i = 2'h0;
   logic [3:0] card_blk_i = 4'h1;
   logic pram_sel_o, rom_sel_o, vram_sel_o, ppa_sel_o, mio_sel_o, card_en_o, write_n_o, rw_o;
   logic busy_o, done_o, irq_pending_o;
   logic [15:0] grp_sel_o;
   logic [15:0] t_a [17] = '{16'h0000, 16'h01ff, 16'h0200, 16'h7c00, 16'h7fff, 16'hffc0,
      16'hfffc, 16'hffbf, 16'h4000, 16'h4003, 16'h4004, 16'h5c03, 16'h6200, 16'h6e07,
      16'h6a05, 16'h6208, 16'h1a34};
   logic [4:0] t_s [17] = '{5'h10, 5'h10, 5'h0, 5'h08, 5'h08, 5'h04, 5'h04, 5'h0, 5'h02,
      5'h02, 5'h0, 5'h0, 5'h01, 5'h01, 5'h01, 5'h0, 5'h0};
   int n_fail = 0, cmp_count = 0, i;
   bad_bus_if bus();
   bad_decode bad_decode_i (.clk_sys_i, .resetn_i, .bus(bus.dev), .ppa_irq_n_i, .irq_jumper_i,
      .card_blk_i, .dev_ready_i, .rd_data_i, .pram_sel_o, .rom_sel_o, .vram_sel_o, .ppa_sel_o,
      .mio_sel_o, .card_en_o, .grp_sel_o, .chip_addr_o, .write_n_o, .rw_o, .wr_data_o);
   bad_master bad_master_i (.clk_sys_i, .resetn_i, .bus(bus.mst), .req_i, .req_we_i,
      .req_addr_i, .req_wdata_i, .nmi_req_i, .busy_o, .done_o, .rdata_o, .irq_pending_o);
   bad_chk bad_chk_i (.clk_sys_i, .resetn_i, .addr(bus.addr), .we(bus.we),
      .phase2_clock(bus.phase2_clock), .cpu_resetn(bus.cpu_resetn),
      .forced_addr_bit15(bus.forced_addr_bit15), .pram_sel_o, .rom_sel_o, .vram_sel_o,
      .ppa_sel_o, .mio_sel_o, .card_en_o, .grp_sel_o, .chip_addr_o, .write_n_o, .rw_o);
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One access through the master; selects are looked at while phase two stands.
   task automatic access(logic w, logic [15:0] a, logic [4:0] s);
      int k;
      req_we_i = w;
      req_addr_i = a;
      req_wdata_i = a[7:0] ^ 8'hff;
      req_i = 1;
      @(negedge clk_sys_i);
      req_i = 0;
      for (k = 0; k < 40 && bus.phase2_clock !== 1'b1; k++) @(negedge clk_sys_i);
      chk("sel", {pram_sel_o, rom_sel_o, vram_sel_o, ppa_sel_o, mio_sel_o}, s);
      chk("card", card_en_o, a[15:12] == card_blk_i);
      chk("grp", grp_sel_o, (a[15:12] == card_blk_i) ? 16'h1 << a[11:8] : 16'h0);
      chk("chip", chip_addr_o, a[7:0]);
      chk("oe", bus.data_d2m_oe, !w && (s != 5'h0 || a[15:12] == card_blk_i));
      @(negedge clk_sys_i);
      chk("wstb", write_n_o, !w);
      chk("rw", rw_o, w);
      if (w) chk("wdat", wr_data_o, req_wdata_i);
      for (k = 0; k < 40 && done_o !== 1'b1; k++) @(negedge clk_sys_i);
      chk("done", done_o, 1'b1);
      if (!w) chk("rdat", rdata_o, rd_data_i);
      @(negedge clk_sys_i);
   endtask
   initial
   begin
      #20000;
      n_fail++;
      summarize();
   end
   initial
   begin
      repeat (5) @(negedge clk_sys_i);
      chk("a15", bus.forced_addr_bit15, 1'b0);
      chk("idle", {pram_sel_o, rom_sel_o, vram_sel_o, ppa_sel_o, mio_sel_o, card_en_o,
         write_n_o, rw_o, bus.irq_n}, 16'h005);
      resetn_i = 1;
      // Board pins need four clocks to pass the synchroniser.
      repeat (4) @(negedge clk_sys_i);
      for (i = 0; i < 17; i++) access(i[0], t_a[i], t_s[i]);
      dev_ready_i = 0;
      repeat (6) @(negedge clk_sys_i);
      fork
         access(1'b0, 16'h4001, 5'h02);
         begin
            repeat (12) @(negedge clk_sys_i);
            chk("stall", {busy_o, done_o}, 16'h2);
            dev_ready_i = 1;
         end
      join
      access(1'b0, 16'h6200, 5'h01);
      for (i = 0; i < 16; i++)
      begin
         {ppa_irq_n_i, irq_jumper_i} = i[3:0];
         repeat (8) @(negedge clk_sys_i);
         chk("irq", irq_pending_o, |(~ppa_irq_n_i & irq_jumper_i));
      end
      nmi_req_i = 1;
      repeat (3) @(negedge clk_sys_i);
      chk("nmi", bus.nmi_n, 1'b0);
      resetn_i = 0;
      @(negedge clk_sys_i);
      chk("rst", {bus.forced_addr_bit15, pram_sel_o, vram_sel_o, write_n_o}, 16'h1);
      summarize();
   end
endmodule
`default_nettype wire
